/* hdl/dasr_pkg.sv */
// Shared constants and types of the dual converter serial readout
package dasr_pkg;

    // Result and frame shape
    localparam int unsigned RESULT_BITS   = 12;
    localparam int unsigned FRAME_BITS    = 32;
    localparam int unsigned COUNT_BITS    = 6;
    localparam int unsigned FIFO_DEPTH    = 16;

    // Falling-edge counts that mark points of a transfer
    localparam logic [5:0] EDGE_TRACK     = 6'h0_D;
    localparam logic [5:0] EDGE_MIN_CONV  = 6'h0_E;
    localparam logic [5:0] EDGE_DOUBLE    = 6'h2_0;

    // Reset values
    localparam logic [2:0] SYNC_CS_RESET  = 3'h7;
    localparam logic [2:0] SYNC_CK_RESET  = 3'h0;
    localparam logic [5:0] COUNT_RESET    = 6'h0_0;

    // One pair of results, one from each converter
    typedef struct packed {
        logic [RESULT_BITS-1:0] result_a;
        logic [RESULT_BITS-1:0] result_b;
    } dasr_pair_t;

    // Pin side outputs of one data line
    typedef struct packed {
        logic data;
        logic oe;
    } dasr_line_t;

    // Transfer phases
    typedef enum logic [2:0] {
        PH_IDLE    = 3'b001,
        PH_CONVERT = 3'b010,
        PH_DONE    = 3'b100
    } dasr_phase_t;

endpackage : dasr_pkg

/* hdl/dasr_fifo.sv */
// Result pair FIFO with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none

module dasr_fifo #(
    parameter int unsigned WIDTH = 24,
    parameter int unsigned DEPTH = 16
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    // Fill side
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    // Drain side
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int unsigned CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
    localparam logic [PW-1:0] LAST_PTR   = PW'(DEPTH - 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wr_ptr;
        logic [PW-1:0]               rd_ptr;
        logic [CW-1:0]               count;
        logic                        full;
        logic                        room;
        logic                        empty;
    } dasr_fifo_state_t;

    dasr_fifo_state_t st;
    dasr_fifo_state_t next_st;
    logic             push;
    logic             pop;

    assign push      = in_valid & ~st.full;
    assign pop       = out_ready & ~st.empty;
    // Ready is a flop of its own so the fill side sees no inverter
    assign in_ready  = st.room;
    assign out_valid = ~st.empty;
    assign out_data  = st.mem[st.rd_ptr];

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wr_ptr] = in_data;
            next_st.wr_ptr = (st.wr_ptr == LAST_PTR) ? '0 : st.wr_ptr + 1'b1;
        end
        if (pop) begin
            next_st.rd_ptr = (st.rd_ptr == LAST_PTR) ? '0 : st.rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            next_st.count = st.count + 1'b1;
        end else if (pop && !push) begin
            next_st.count = st.count - 1'b1;
        end
        // Registered flags keep both ready and valid glitch free
        next_st.full  = (next_st.count == FULL_COUNT);
        next_st.room  = (next_st.count != FULL_COUNT);
        next_st.empty = (next_st.count == '0);
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st       <= '0;
            st.empty <= 1'b1;
            st.room  <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

endmodule // dasr_fifo

`default_nettype wire

/* hdl/dasr_readout.sv */
// Serial readout port of the dual 12-bit sampling converter
`timescale 1ns/10ps
`default_nettype none

// How it works
// RULE1 - Serial clock drives conversion and bit shifting
// RULE2 - Select falling: hold, drive lines, start
// RULE3 - One result needs at least 14 clocks
// RULE4 - After 13 falls, track on next rise
// RULE5 - Sixteen clock transfer ends with two zeros
// RULE6 - Select rising aborts and releases both lines
// RULE7 - Primary line then shifts second converter result
// RULE8 - Secondary line then shifts first converter result
// RULE9 - Double read releases line at 32nd fall
// RULE10 - First zero at select fall, second next
// RULE11 - Result msb first, lsb launched 13th fall
// RULE12 - Slow host may capture on rising edges
// RULE13 - Rise before first fall is ignored
// RULE14 - Fall coincident with select fall not counted
// RULE15 - After select rises, idle with lines released
module dasr_readout #(
    parameter int unsigned FIFO_WORDS = dasr_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                ref_clk,
    input  wire logic                rst_n,
    // Serial pins from the host
    input  wire logic                cs_n,
    input  wire logic                conversion_serial_clock,
    // Data line pins, each a three-state output
    output logic                     primary_data_line_out,
    output logic                     primary_data_line_oe,
    output logic                     secondary_data_line_out,
    output logic                     secondary_data_line_oe,
    // Result pairs from the converter cores
    input  wire dasr_pkg::dasr_pair_t pair_data,
    input  wire logic                pair_valid,
    output logic                     pair_ready,
    // Status
    output logic                     track_hold,
    output logic                     conversion_busy,
    output logic                     result_done,
    output logic                     frame_aborted,
    output logic                     pair_underrun
);
    import dasr_pkg::*;

    localparam int unsigned PAIR_BITS = 2 * RESULT_BITS;

    typedef struct packed {
        logic [2:0]            cs_sync;
        logic [2:0]            ck_sync;
        dasr_phase_t           phase;
        logic [COUNT_BITS-1:0] fall_count;
        logic [FRAME_BITS-1:0] shift_a;
        logic [FRAME_BITS-1:0] shift_b;
        dasr_line_t            line_a;
        dasr_line_t            line_b;
        logic                  hold;
        logic                  done;
        logic                  aborted;
        logic                  underrun;
    } dasr_state_t;

    dasr_state_t st;
    dasr_state_t next_st;

    // Edges of the synchronised pins
    logic       cs_fall;
    logic       cs_rise;
    logic       ck_fall;
    logic       ck_rise;

    // Drain side of the pair buffer
    dasr_pair_t fifo_pair;
    logic       fifo_valid;
    logic       fifo_take;
    dasr_pair_t loaded;

    // Count after the falling edge being handled this cycle
    logic [COUNT_BITS-1:0] count_inc;

    // Only the second stage and its follower feed the edge finders
    assign cs_fall = st.cs_sync[2] & ~st.cs_sync[1];
    assign cs_rise = ~st.cs_sync[2] & st.cs_sync[1];
    assign ck_fall = st.ck_sync[2] & ~st.ck_sync[1]; // RULE1
    assign ck_rise = ~st.ck_sync[2] & st.ck_sync[1];

    assign count_inc = st.fall_count + 1'b1;

    // A pair is taken only at the sampling instant
    assign fifo_take = cs_fall && (st.phase == PH_IDLE);

    dasr_fifo #(
        .WIDTH (PAIR_BITS),
        .DEPTH (FIFO_WORDS)
    ) u_pair_fifo (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .in_data   (pair_data),
        .in_valid  (pair_valid),
        .in_ready  (pair_ready),
        .out_data  (fifo_pair),
        .out_valid (fifo_valid),
        .out_ready (fifo_take)
    );

    // An empty buffer gives a zero result rather than stale data
    assign loaded = fifo_valid ? fifo_pair : '0;

    always_comb begin
        next_st          = st;
        next_st.cs_sync  = {st.cs_sync[1:0], cs_n};
        next_st.ck_sync  = {st.ck_sync[1:0], conversion_serial_clock};
        next_st.done     = 1'b0;
        next_st.aborted  = 1'b0;
        next_st.underrun = 1'b0;

        unique case (st.phase)
            PH_IDLE: begin
                next_st.fall_count = COUNT_RESET; // RULE15
                next_st.line_a.oe  = 1'b0;
                next_st.line_b.oe  = 1'b0;
                next_st.hold       = 1'b0;
                // A clock fall in this same cycle is ignored here
                if (cs_fall) begin // RULE14
                    next_st.phase    = PH_CONVERT; // RULE2
                    next_st.hold     = 1'b1; // RULE2
                    next_st.line_a.oe = 1'b1; // RULE2
                    next_st.line_b.oe = 1'b1; // RULE2
                    next_st.underrun = ~fifo_valid;
                    // Two zeros, own result, two zeros, then the same around the other result
                    next_st.shift_a = {2'b00, loaded.result_a, 2'b00, // RULE5
                                       2'b00, loaded.result_b, 2'b00}; // RULE7
                    next_st.shift_b = {2'b00, loaded.result_b, 2'b00, // RULE5
                                       2'b00, loaded.result_a, 2'b00}; // RULE8
                end
            end

            PH_CONVERT: begin
                if (cs_rise) begin
                    next_st.phase     = PH_IDLE; // RULE6
                    next_st.line_a.oe = 1'b0; // RULE6
                    next_st.line_b.oe = 1'b0; // RULE6
                    next_st.hold      = 1'b0;
                    next_st.fall_count = COUNT_RESET; // RULE15
                    // Host cut the conversion short of its minimum
                    next_st.aborted = (st.fall_count < EDGE_MIN_CONV); // RULE3
                end else begin
                    // Rises before the first counted fall have no effect
                    if (ck_rise && st.fall_count >= EDGE_TRACK) begin // RULE13
                        next_st.hold = 1'b0; // RULE4
                    end
                    if (ck_fall) begin
                        next_st.fall_count = count_inc;
                        next_st.shift_a = {st.shift_a[FRAME_BITS-2:0], 1'b0}; // RULE11
                        next_st.shift_b = {st.shift_b[FRAME_BITS-2:0], 1'b0}; // RULE11
                        if (count_inc == EDGE_MIN_CONV) begin
                            next_st.done = 1'b1; // RULE3
                        end
                        if (count_inc == EDGE_DOUBLE) begin
                            next_st.phase     = PH_DONE; // RULE9
                            next_st.line_a.oe = 1'b0; // RULE9
                            next_st.line_b.oe = 1'b0; // RULE9
                        end
                    end
                end
            end

            PH_DONE: begin
                // Lines stay released until the host ends the frame
                if (cs_rise) begin
                    next_st.phase      = PH_IDLE; // RULE15
                    next_st.fall_count = COUNT_RESET;
                end
            end
        endcase

        // Line shows the head of its shift register: the first zero at
        // the select fall, then one new bit per counted falling edge
        next_st.line_a.data = next_st.line_a.oe & next_st.shift_a[FRAME_BITS-1]; // RULE10
        next_st.line_b.data = next_st.line_b.oe & next_st.shift_b[FRAME_BITS-1]; // RULE10
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st            <= '0;
            st.cs_sync    <= SYNC_CS_RESET;
            st.ck_sync    <= SYNC_CK_RESET;
            st.phase      <= PH_IDLE;
            st.fall_count <= COUNT_RESET;
        end else begin
            st <= next_st;
        end
    end

    // All outputs come straight from the state register
    assign primary_data_line_out   = st.line_a.data;
    assign primary_data_line_oe    = st.line_a.oe;
    assign secondary_data_line_out = st.line_b.data;
    assign secondary_data_line_oe  = st.line_b.oe;
    assign track_hold              = st.hold;
    assign conversion_busy         = st.phase[1];
    assign result_done             = st.done;
    assign frame_aborted           = st.aborted;
    assign pair_underrun           = st.underrun;

endmodule // dasr_readout

`default_nettype wire

/* dv/dasr_readout_assertions.sv */
// Checker of the readout pin and status timing
`timescale 1ns/10ps
`default_nettype none
module dasr_readout_assertions (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Serial pins
    input wire logic cs_n,
    input wire logic conversion_serial_clock,
    input wire logic primary_data_line_out,
    input wire logic primary_data_line_oe,
    input wire logic secondary_data_line_out,
    input wire logic secondary_data_line_oe,
    // Pairs and status
    input wire dasr_pkg::dasr_pair_t pair_data,
    input wire logic pair_valid,
    input wire logic pair_ready,
    input wire logic track_hold,
    input wire logic conversion_busy,
    input wire logic result_done,
    input wire logic frame_aborted,
    input wire logic pair_underrun
);
    import dasr_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_idle_released: assert property (cs_n[*5] |-> !primary_data_line_oe
        && !secondary_data_line_oe && !conversion_busy) else $error("lines driven while idle");
    a_busy_drives: assert property (conversion_busy == primary_data_line_oe
        && conversion_busy == secondary_data_line_oe) else $error("drive and busy differ");
    a_start_zero: assert property ($rose(conversion_busy) |-> track_hold
        && !primary_data_line_out && !secondary_data_line_out) else $error("bad frame start");
    a_start_cause: assert property ($rose(conversion_busy) |-> !$past(cs_n, 3))
        else $error("frame began without select");
    a_done_tracks: assert property (result_done |-> conversion_busy && !track_hold)
        else $error("result done while holding");
    a_track_on_rise: assert property ($fell(track_hold) && conversion_busy
        |-> $past(conversion_serial_clock, 2)) else $error("track without clock rise");
    a_done_pulse: assert property (result_done |=> !result_done)
        else $error("done pulse too long");
    a_abort_pulse: assert property (frame_aborted |-> cs_n && !result_done
        ##1 !frame_aborted) else $error("bad abort pulse");
    a_hold_in_frame: assert property (track_hold |-> conversion_busy)
        else $error("hold outside a frame");
    a_underrun_start: assert property (pair_underrun |-> conversion_busy
        ##1 !pair_underrun) else $error("bad underrun pulse");
endmodule // dasr_readout_assertions

bind dasr_readout dasr_readout_assertions i_dasr_readout_assertions (.ref_clk, .rst_n,
    .cs_n, .conversion_serial_clock, .primary_data_line_out, .primary_data_line_oe,
    .secondary_data_line_out, .secondary_data_line_oe, .pair_data, .pair_valid,
    .pair_ready, .track_hold, .conversion_busy, .result_done, .frame_aborted, .pair_underrun);
`default_nettype wire

/* dv/dasr_host_model.sv */
// Behavioural host serial port: select, serial clock and bit capture
`timescale 1ns/10ps
`default_nettype none
module dasr_host_model (
    // Clock
    input  wire logic   ref_clk,
    // Serial pins
    output logic        cs_n,
    output logic        sclk,
    input  wire logic   a_out,
    input  wire logic   a_oe,
    input  wire logic   b_out,
    input  wire logic   b_oe,
    // Captured bits and drive state just before select rises
    output logic [31:0] cap_a,
    output logic [31:0] cap_b,
    output logic [31:0] rise_a,
    output logic [1:0]  oe_end
);
    initial begin
        cs_n = 1'h1;
        sclk = 1'h1;
    end
    // Half period of 4 cycles gives the 64 ns serial clock
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // Mode 1 leads with a rise, mode 2 falls with select
    task automatic frame(input int n, input int mode);
        cap_a = 32'h0000_0000;
        cap_b = 32'h0000_0000;
        rise_a = 32'h0000_0000;
        sclk = (mode != 1);
        tick(4);
        cs_n = 1'h0;
        if (mode == 2) sclk = 1'h0;
        tick(4);
        sclk = 1'h1;
        tick(4);
        for (int k = 0; k < n; k++) begin
            // A released line reads as unknown so a late bit cannot pass
            cap_a = {cap_a[30:0], a_oe ? a_out : 1'hx};
            cap_b = {cap_b[30:0], b_oe ? b_out : 1'hx};
            sclk = 1'h0;
            tick(4);
            // Slow host view: take line A at each rise; the rise after the
            // last fall is left out as a full frame has released the line
            if (k < n - 1) rise_a = {rise_a[30:0], a_oe ? a_out : 1'hx};
            sclk = 1'h1;
            tick(4);
        end
        oe_end = {a_oe, b_oe};
        cs_n = 1'h1;
        tick(12);
    endtask
endmodule // dasr_host_model
`default_nettype wire

/* dv/test_dasr_readout.sv */
// Self-checking bench of the dual converter serial readout
`timescale 1ns/10ps
`default_nettype none
module test_dasr_readout;
    import dasr_pkg::*;
    logic        ref_clk = 1'h0;
    logic        rst_n = 1'h0;
    logic        cs_n, sclk, a_out, a_oe, b_out, b_oe;
    dasr_pair_t  pair_data = '0;
    logic        pair_valid = 1'h0;
    logic        pair_ready, track_hold, busy, done, aborted, underrun;
    logic [31:0] cap_a, cap_b, rise_a, r;
    int          n_done = 0, n_abort = 0, n_under = 0;
    int          exp_done = 0, exp_abort = 0, exp_under = 0;
    logic [1:0]  oe_end;
    int          err_total = 0;
    int          total_checks = 0;
    int          seed = 32'h3adc;
    int          cycles = 0;
    int          n;
    int          lens[6] = '{14, 16, 32, 13, 3, 15};
    dasr_pair_t  q[$];
    dasr_pair_t  p;

    dasr_readout i_dasr_readout (.ref_clk(ref_clk), .rst_n(rst_n), .cs_n(cs_n),
        .conversion_serial_clock(sclk), .primary_data_line_out(a_out),
        .primary_data_line_oe(a_oe), .secondary_data_line_out(b_out),
        .secondary_data_line_oe(b_oe), .pair_data(pair_data), .pair_valid(pair_valid),
        .pair_ready(pair_ready), .track_hold(track_hold), .conversion_busy(busy),
        .result_done(done), .frame_aborted(aborted), .pair_underrun(underrun));
    dasr_host_model i_dasr_host_model (.ref_clk(ref_clk), .cs_n(cs_n), .sclk(sclk),
        .a_out(a_out), .a_oe(a_oe), .b_out(b_out), .b_oe(b_oe), .cap_a(cap_a),
        .cap_b(cap_b), .rise_a(rise_a), .oe_end(oe_end));

    always #4 ref_clk = ~ref_clk;

    // Status pulses are counted at the falling edge, where they have settled
    always @(negedge ref_clk) begin
        if (done === 1'h1) n_done <= n_done + 1;
        if (aborted === 1'h1) n_abort <= n_abort + 1;
        if (underrun === 1'h1) n_under <= n_under + 1;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Leading zeros, own result, four zeros, other result, trailing zeros
    function automatic logic [31:0] word(input logic [11:0] own, oth, input int n);
        logic [31:0] w;
        w = {2'h0, own, 4'h0, oth, 2'h0};
        return w >> (32 - n);
    endfunction

    // Valid stays up across a burst so it never toggles within one step
    task automatic push(input dasr_pair_t v);
        pair_data = v;
        pair_valid = 1'h1;
        while (pair_ready !== 1'h1) @(negedge ref_clk);
        @(negedge ref_clk);
    endtask

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            $display("ERROR %0t run timed out", $time);
            wrap_up();
        end
    end

    initial begin
        repeat (6) @(negedge ref_clk);
        rst_n = 1'h1;
        @(negedge ref_clk);
        check({a_oe, b_oe, track_hold, busy, pair_ready}, 32'h0000_0001);
        for (int i = 0; i < 16; i++) begin
            r = $random(seed);
            q.push_back(r[23:0]);
            push(r[23:0]);
        end
        pair_data = 24'h00_0abc;
        repeat (3) @(negedge ref_clk);
        check(pair_ready, 32'h0000_0000);
        pair_valid = 1'h0;
        $display("fill test done");
        // The last frames find the buffer empty and must send zeros
        for (int i = 0; i < 20; i++) begin
            n = (i < 6) ? lens[i] : 14 + ($unsigned($random(seed)) % 19);
            p = (q.size() > 0) ? q.pop_front() : '0;
            i_dasr_host_model.frame(n, i % 3);
            check(cap_a, word(p.result_a, p.result_b, n));
            check(cap_b, word(p.result_b, p.result_a, n));
            check({30'h0, oe_end}, (n == 32) ? 32'h0 : 32'h3);
            exp_done += (n >= 14) ? 1 : 0;
            exp_abort += (n < 14) ? 1 : 0;
            exp_under += (i >= 16) ? 1 : 0;
            check(rise_a, word(p.result_a, p.result_b, n));
            check(n_done, exp_done);
            check(n_abort, exp_abort);
            check(n_under, exp_under);
            check({a_oe, b_oe, busy, track_hold}, 32'h0000_0000);
            $display("frame %0d of %0d clocks done", i, n);
        end
        wrap_up();
    end
endmodule // test_dasr_readout
`default_nettype wire
